// File: rtl/cpsb_edge.sv
// Edge detector for one sampled level, a sideband line or power good
`timescale 1ns/100ps
module cpsb_edge
  import cpsb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b1;
    end else if (clk_en) begin
      prev_q <= level;
    end
  end

  assign rise = clk_en & level & ~prev_q;
  assign fall = clk_en & ~level & prev_q;
endmodule : cpsb_edge

// File: rtl/cpsb_pkg.sv
// Package for the processor sideband and power signalling block
package cpsb_pkg;
  // AXI4-Lite register byte offsets
  localparam logic [7:0] CPSB_OFF_CTRL = 8'h00;
  localparam logic [7:0] CPSB_OFF_SIDEBAND = 8'h04;
  localparam logic [7:0] CPSB_OFF_STATE = 8'h08;
  localparam logic [7:0] CPSB_OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] CPSB_OFF_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] CPSB_OFF_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] CPSB_OFF_VREG_WAIT = 8'h18;
  // Control register field positions
  localparam int CPSB_CTRL_COPROC_ERR = 0;
  localparam int CPSB_CTRL_THERM_ALERT = 1;
  localparam int CPSB_CTRL_MB_CLK_PULL = 2;
  localparam int CPSB_CTRL_MB_DATA_PULL = 3;
  localparam logic [31:0] CPSB_CTRL_RESET = 32'h0000_0000;
  // Interrupt event bit positions
  localparam int CPSB_EV_SLEEP_ENTER = 0;
  localparam int CPSB_EV_SLEEP_EXIT = 1;
  localparam int CPSB_EV_MGMT_INT = 2;
  localparam int CPSB_EV_INIT = 3;
  localparam int CPSB_EV_NMI = 4;
  localparam int CPSB_EV_SUSPEND = 5;
  localparam int CPSB_EV_PGOOD = 6;
  localparam int CPSB_NUM_EV = 7;
  localparam logic [6:0] CPSB_IRQ_RESET = 7'h00;
  // Regulator settle time before power good
  localparam int CPSB_VREG_SETTLE_US = 10;
  localparam int CPSB_CLK_MHZ = 100;
  localparam logic [15:0] CPSB_VREG_WAIT_RESET = 16'(CPSB_VREG_SETTLE_US * CPSB_CLK_MHZ);
  localparam logic [1:0] CPSB_RESP_OKAY = 2'b00;
  localparam logic [1:0] CPSB_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    CPSB_RUN = 2'b00,
    CPSB_LIGHT_SLEEP = 2'b01
  } cpsb_cpu_state_type;

  // Sideband lines as received from the bridge, low means asserted where named _n
  typedef struct packed {
    logic ignore_error_n;
    logic cpu_init_n;
    logic cpu_int_req;
    logic nmi;
    logic addr20_mask_n;
    logic sys_mgmt_int_n;
    logic stop_clock_req_n;
    logic suspend_state_n;
  } cpsb_sideband_type;
endpackage : cpsb_pkg

// File: rtl/cpsb_top.sv
// Processor sideband and power-management signalling with AXI4-Lite control
`timescale 1ns/100ps
module cpsb_top
  import cpsb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sideband inputs from the bridge, already resolved wire levels
  input wire cpsb_sideband_type sideband_in,
  input wire logic cpu_addr20_in,
  input wire logic vreg_enable,
  input wire logic cpu_reset_unused,
  input wire logic cache_sleep_unused,
  // Outputs and management bus pins toward the connector
  output logic coproc_error_n,
  output logic cpu_addr20_out,
  output logic vreg_power_good,
  output logic thermal_alert_n_o,
  output logic thermal_alert_n_oe_n,
  input wire logic mgmt_bus_clock_i,
  output logic mgmt_bus_clock_o,
  output logic mgmt_bus_clock_oe_n,
  input wire logic mgmt_bus_data_i,
  output logic mgmt_bus_data_o,
  output logic mgmt_bus_data_oe_n,
  output logic cpu_sleeping,
  output logic irq
);
  logic [31:0] ctrl_q;
  logic [15:0] vreg_wait_q;
  logic [15:0] vreg_cnt_q;
  logic pgood_q;
  cpsb_sideband_type sb_q;
  cpsb_cpu_state_type state_q;
  cpsb_cpu_state_type state_d;
  logic [CPSB_NUM_EV-1:0] irq_status_q;
  logic [CPSB_NUM_EV-1:0] irq_enable_q;
  logic [CPSB_NUM_EV-1:0] ev_set;
  logic [CPSB_NUM_EV-1:0] ev_clr;
  logic [1:0] nmi_edge;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic wr_unmapped;
  logic mgmt_fall;
  logic init_fall;
  logic susp_fall;
  logic pg_rise;

  // Inputs are synchronous; one register stage gives a clean sample point
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Idle levels, so that no edge detector sees a false event after reset
      sb_q <= '{default: 1'b1, cpu_int_req: 1'b0, nmi: 1'b0};
    end else if (clk_en) begin
      sb_q <= sideband_in;
    end
  end

  // Light sleep machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      CPSB_RUN: begin
        if (!sb_q.stop_clock_req_n) begin
          state_d = CPSB_LIGHT_SLEEP;
        end
      end
      CPSB_LIGHT_SLEEP: begin
        if (sb_q.stop_clock_req_n) begin
          state_d = CPSB_RUN;
        end
      end
      default: state_d = CPSB_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= CPSB_RUN;
      cpu_sleeping <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cpu_sleeping <= (state_d == CPSB_LIGHT_SLEEP);
    end
  end

  // Address bit 20 forced low while the mask line is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_addr20_out <= 1'b0;
    end else if (clk_en) begin
      cpu_addr20_out <= cpu_addr20_in & sideband_in.addr20_mask_n;
    end
  end

  // Power good waits a programmable settle time after enable; drops at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vreg_cnt_q <= '0;
      pgood_q <= 1'b0;
    end else if (clk_en) begin
      if (!vreg_enable) begin
        vreg_cnt_q <= '0;
        pgood_q <= 1'b0;
      end else if (vreg_cnt_q >= vreg_wait_q) begin
        pgood_q <= 1'b1;
      end else begin
        vreg_cnt_q <= vreg_cnt_q + 16'h0001;
      end
    end
  end

  // Pin drivers; open-drain pins enable only to pull low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coproc_error_n <= 1'b1;
      vreg_power_good <= 1'b0;
      thermal_alert_n_o <= 1'b0;
      thermal_alert_n_oe_n <= 1'b1;
      mgmt_bus_clock_o <= 1'b0;
      mgmt_bus_clock_oe_n <= 1'b1;
      mgmt_bus_data_o <= 1'b0;
      mgmt_bus_data_oe_n <= 1'b1;
    end else if (clk_en) begin
      coproc_error_n <= ~ctrl_q[CPSB_CTRL_COPROC_ERR];
      vreg_power_good <= pgood_q;
      thermal_alert_n_oe_n <= ~ctrl_q[CPSB_CTRL_THERM_ALERT];
      mgmt_bus_clock_oe_n <= ~ctrl_q[CPSB_CTRL_MB_CLK_PULL];
      mgmt_bus_data_oe_n <= ~ctrl_q[CPSB_CTRL_MB_DATA_PULL];
    end
  end

  // Event detection
  cpsb_edge u_mgmt (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .level(sb_q.sys_mgmt_int_n), .rise(), .fall(mgmt_fall)
  );
  cpsb_edge u_init (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .level(sb_q.cpu_init_n), .rise(), .fall(init_fall)
  );
  cpsb_edge u_susp (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .level(sb_q.suspend_state_n), .rise(), .fall(susp_fall)
  );
  cpsb_edge u_nmi (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .level(~sb_q.nmi), .rise(), .fall(nmi_edge[0])
  );
  cpsb_edge u_pg (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .level(~pgood_q), .rise(), .fall(pg_rise)
  );
  assign nmi_edge[1] = 1'b0;

  always_comb begin
    ev_set = '0;
    ev_set[CPSB_EV_SLEEP_ENTER] = (state_q == CPSB_RUN) && (state_d == CPSB_LIGHT_SLEEP);
    ev_set[CPSB_EV_SLEEP_EXIT] = (state_q == CPSB_LIGHT_SLEEP) && (state_d == CPSB_RUN);
    ev_set[CPSB_EV_MGMT_INT] = mgmt_fall;
    ev_set[CPSB_EV_INIT] = init_fall;
    ev_set[CPSB_EV_NMI] = nmi_edge[0];
    ev_set[CPSB_EV_SUSPEND] = susp_fall;
    ev_set[CPSB_EV_PGOOD] = pg_rise;
  end

  // AXI4-Lite write path: address and data in either order
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_unmapped = (aw_addr_q > CPSB_OFF_VREG_WAIT) || (aw_addr_q[1:0] != 2'b00);
  assign ev_clr = (do_write && aw_addr_q == CPSB_OFF_IRQ_CLEAR && w_strb_q[0]) ?
                  w_data_q[CPSB_NUM_EV-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CPSB_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_unmapped ? CPSB_RESP_SLVERR : CPSB_RESP_OKAY;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CPSB_CTRL_RESET;
      irq_enable_q <= CPSB_IRQ_RESET;
      vreg_wait_q <= CPSB_VREG_WAIT_RESET;
    end else if (clk_en && do_write) begin
      if (aw_addr_q == CPSB_OFF_CTRL && w_strb_q[0]) begin
        ctrl_q[7:0] <= {4'h0, w_data_q[3:0]};
      end
      if (aw_addr_q == CPSB_OFF_IRQ_ENABLE && w_strb_q[0]) begin
        irq_enable_q <= w_data_q[CPSB_NUM_EV-1:0];
      end
      if (aw_addr_q == CPSB_OFF_VREG_WAIT) begin
        if (w_strb_q[0]) vreg_wait_q[7:0] <= w_data_q[7:0];
        if (w_strb_q[1]) vreg_wait_q[15:8] <= w_data_q[15:8];
      end
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= CPSB_IRQ_RESET;
      irq <= 1'b0;
    end else if (clk_en) begin
      irq_status_q <= (irq_status_q & ~ev_clr) | ev_set;
      irq <= |(((irq_status_q & ~ev_clr) | ev_set) & irq_enable_q);
    end
  end

  // AXI4-Lite read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= CPSB_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= CPSB_RESP_OKAY;
        case (s_axi_araddr)
          CPSB_OFF_CTRL: s_axi_rdata <= ctrl_q;
          CPSB_OFF_SIDEBAND: s_axi_rdata <= {22'h0, mgmt_bus_data_i, mgmt_bus_clock_i, sb_q};
          CPSB_OFF_STATE: s_axi_rdata <= {30'h0, vreg_power_good, cpu_sleeping};
          CPSB_OFF_IRQ_STATUS: s_axi_rdata <= {25'h0, irq_status_q};
          CPSB_OFF_IRQ_CLEAR: s_axi_rdata <= 32'h0000_0000;
          CPSB_OFF_IRQ_ENABLE: s_axi_rdata <= {25'h0, irq_enable_q};
          CPSB_OFF_VREG_WAIT: s_axi_rdata <= {16'h0, vreg_wait_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= CPSB_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // The unused reset and cache-sleep pins are accepted and ignored
  logic unused_pins;
  assign unused_pins = cpu_reset_unused ^ cache_sleep_unused ^ nmi_edge[1];

  // Checks
  AST_SLEEP_ENTER: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !sb_q.stop_clock_req_n |=> state_q == CPSB_LIGHT_SLEEP)
    else $error("Stop-clock request did not enter sleep");
  AST_SLEEP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == CPSB_LIGHT_SLEEP && !sb_q.stop_clock_req_n |=> state_q == CPSB_LIGHT_SLEEP)
    else $error("Left sleep while request asserted");
  AST_ADDR_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !sideband_in.addr20_mask_n |=> !cpu_addr20_out)
    else $error("Address bit 20 not masked");
  AST_COPROC: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && $past(clk_en) |-> coproc_error_n == !$past(ctrl_q[CPSB_CTRL_COPROC_ERR]))
    else $error("Coprocessor error output mismatch");
  AST_PGOOD_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !vreg_enable ##1 clk_en |=> !vreg_power_good)
    else $error("Power good high without regulator enable");
  AST_THERM_OD: assert property (@(posedge aclk) disable iff (!aresetn)
    !thermal_alert_n_o)
    else $error("Thermal alert drives high");
  AST_MB_OD: assert property (@(posedge aclk) disable iff (!aresetn)
    !mgmt_bus_clock_o && !mgmt_bus_data_o)
    else $error("Management bus drives high");
  AST_MGMT_EV: assert property (@(posedge aclk) disable iff (!aresetn)
    mgmt_fall |=> irq_status_q[CPSB_EV_MGMT_INT])
    else $error("Management interrupt event lost");
  AST_INIT_EV: assert property (@(posedge aclk) disable iff (!aresetn)
    init_fall |=> irq_status_q[CPSB_EV_INIT])
    else $error("Init event lost");
  AST_NMI_EV: assert property (@(posedge aclk) disable iff (!aresetn)
    nmi_edge[0] |=> irq_status_q[CPSB_EV_NMI])
    else $error("Non-maskable interrupt event lost");
  AST_FREEZE: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_en |=> $stable(state_q) && $stable(irq_status_q))
    else $error("State moved while clock enable low");
endmodule : cpsb_top

// File: sim/cpsb_bridge_model.sv
// Model of the bridge and power electronics on the far side of the sideband pins
`timescale 1ns/100ps
module cpsb_bridge_model
  import cpsb_pkg::*;
(
  input wire logic aclk,
  input wire logic [7:0] assert_req,
  input wire logic suspend_b_req,
  input wire logic [1:0] mb_pull,
  input wire logic [1:0] dut_mb_oe_n,
  input wire logic [1:0] dut_mb_o,
  output cpsb_sideband_type sideband,
  output logic vreg_enable,
  output logic mb_clock,
  output logic mb_data
);
  logic [7:0] pull_q;
  logic sus_b_q;
  initial begin
    pull_q = 8'h00;
    sus_b_q = 1'b0;
  end
  // The bridge moves its sideband and regulator-enable lines only at the clock edge; the bus lines follow at once
  always @(posedge aclk) begin
    pull_q <= assert_req;
    sus_b_q <= suspend_b_req;
  end
  // Released lines float high; active-high lines are pulled low while not asserted
  assign sideband = ~(pull_q ^ 8'h30);
  assign vreg_enable = sus_b_q;
  assign mb_clock = ~mb_pull[0] & (dut_mb_oe_n[0] | dut_mb_o[0]);
  assign mb_data = ~mb_pull[1] & (dut_mb_oe_n[1] | dut_mb_o[1]);
endmodule : cpsb_bridge_model

// File: sim/test_cpu_sideband_power_signals.sv
// Self-checking bench for the sideband and power-management block
`timescale 1ns/100ps
module test_cpu_sideband_power_signals;
  import cpsb_pkg::*;
  logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, assert_req;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, v;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, mb_pull;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  cpsb_sideband_type sideband_in;
  logic cpu_addr20_in, vreg_enable, cpu_reset_unused, cache_sleep_unused, sus_b;
  logic coproc_error_n, cpu_addr20_out, vreg_power_good, thermal_alert_n_o, thermal_alert_n_oe_n;
  logic mgmt_bus_clock_i, mgmt_bus_clock_o, mgmt_bus_clock_oe_n, cpu_sleeping, irq;
  logic mgmt_bus_data_i, mgmt_bus_data_o, mgmt_bus_data_oe_n;
  int errors, checks_done, n;
  int evs[5] = '{0, 2, 3, 4, 5};
  int pins[5] = '{1, 2, 6, 4, 0};

  cpsb_top u_dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sideband_in, .cpu_addr20_in, .vreg_enable,
    .cpu_reset_unused, .cache_sleep_unused, .coproc_error_n, .cpu_addr20_out,
    .vreg_power_good, .thermal_alert_n_o, .thermal_alert_n_oe_n, .mgmt_bus_clock_i,
    .mgmt_bus_clock_o, .mgmt_bus_clock_oe_n, .mgmt_bus_data_i, .mgmt_bus_data_o,
    .mgmt_bus_data_oe_n, .cpu_sleeping, .irq);
  cpsb_bridge_model u_bridge (.aclk, .assert_req, .suspend_b_req(sus_b), .mb_pull,
    .dut_mb_oe_n({mgmt_bus_data_oe_n, mgmt_bus_clock_oe_n}),
    .dut_mb_o({mgmt_bus_data_o, mgmt_bus_clock_o}), .sideband(sideband_in), .vreg_enable,
    .mb_clock(mgmt_bus_clock_i), .mb_data(mgmt_bus_data_i));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [7:0] lvl(input logic [7:0] q);
    return ~(q ^ 8'h30);
  endfunction : lvl

  task automatic chk_bit(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %b, seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic axw(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axw

  // Read one register and compare data and response together
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    chk_word(nm, e, s_axi_rdata);
    chk_word(nm, 32'(er), 32'(s_axi_rresp));
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rchk

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    end_of_test();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, assert_req, mb_pull} = '0;
    {cpu_addr20_in, cpu_reset_unused, cache_sleep_unused, sus_b} = '0;
    clk_en = 1'b1;
    s_axi_wstrb = 4'hf;
    errors = 0;
    checks_done = 0;
    d = $urandom(32'h0000_e193);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_bit("power good", 1'b0, vreg_power_good);
    chk_bit("coproc error", 1'b1, coproc_error_n);
    chk_bit("thermal oe", 1'b1, thermal_alert_n_oe_n);
    rchk("status after reset", CPSB_OFF_IRQ_STATUS, 32'h0000_0000, CPSB_RESP_OKAY);
    rchk("vreg wait", CPSB_OFF_VREG_WAIT, 32'(CPSB_VREG_WAIT_RESET), CPSB_RESP_OKAY);
    rchk("unmapped read", 8'h40, 32'h0000_0000, CPSB_RESP_SLVERR);
    axw(8'h44, 32'h0000_000f, r);
    chk_word("unmapped write", 32'(CPSB_RESP_SLVERR), 32'(r));
    $display("test reset finished");
    for (int i = 0; i < 6; i++) begin
      v = 4'($urandom);
      mb_pull <= 2'($urandom);
      assert_req <= 8'($urandom);
      axw(CPSB_OFF_CTRL, {28'h000_0000, v}, r);
      repeat (4) @(posedge aclk);
      chk_bit("coproc error", ~v[0], coproc_error_n);
      chk_bit("thermal wire", ~v[1], thermal_alert_n_oe_n | thermal_alert_n_o);
      rchk("sideband", CPSB_OFF_SIDEBAND, {22'h00_0000, ~v[3] & ~mb_pull[1], ~v[2] & ~mb_pull[0],
        lvl(assert_req)}, CPSB_RESP_OKAY);
    end
    assert_req <= 8'h00;
    $display("test lines finished");
    @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      v = 4'($urandom);
      assert_req[3] <= v[0];
      cpu_addr20_in <= v[1];
      cpu_reset_unused <= v[2];
      cache_sleep_unused <= v[3];
      repeat (6) @(posedge aclk);
      chk_bit("addr20", v[1] & ~v[0], cpu_addr20_out);
    end
    assert_req[3] <= 1'b0;
    $display("test address mask finished");
    axw(CPSB_OFF_IRQ_ENABLE, 32'h0000_007f, r);
    for (int k = 0; k < 5; k++) begin
      axw(CPSB_OFF_IRQ_CLEAR, 32'h0000_007f, r);
      assert_req[pins[k]] <= 1'b1;
      repeat (6) @(posedge aclk);
      rchk("status", CPSB_OFF_IRQ_STATUS, 32'(1) << evs[k], CPSB_RESP_OKAY);
      chk_bit("irq", 1'b1, irq);
      for (int j = 0; j < 20 && k == 0; j++) begin
        @(posedge aclk);
        chk_bit("sleeping", 1'b1, cpu_sleeping);
      end
      assert_req[pins[k]] <= 1'b0;
      repeat (6) @(posedge aclk);
      if (k == 0) chk_bit("sleeping", 1'b0, cpu_sleeping);
    end
    // Suspend event left pending: masking must drop the line with status kept
    axw(CPSB_OFF_IRQ_ENABLE, 32'h0000_0000, r);
    repeat (3) @(posedge aclk);
    chk_bit("irq masked", 1'b0, irq);
    rchk("status kept", CPSB_OFF_IRQ_STATUS, 32'h0000_0020, CPSB_RESP_OKAY);
    axw(CPSB_OFF_IRQ_CLEAR, 32'h0000_007f, r);
    rchk("status cleared", CPSB_OFF_IRQ_STATUS, 32'h0000_0000, CPSB_RESP_OKAY);
    $display("test events finished");
    axw(CPSB_OFF_VREG_WAIT, 32'h0000_0004, r);
    sus_b <= 1'b1;
    n = 0;
    while (!vreg_power_good && n < 40) begin
      @(posedge aclk);
      n++;
    end
    chk_bit("power good delay", 1'b1, n >= 4 && n <= 12);
    rchk("pgood event", CPSB_OFF_IRQ_STATUS, 32'h0000_0040, CPSB_RESP_OKAY);
    sus_b <= 1'b0;
    repeat (8) @(posedge aclk);
    chk_bit("power good off", 1'b0, vreg_power_good);
    $display("test power good finished");
    // Clock enable low must freeze the sleep machine although the request stands
    clk_en <= 1'b0;
    assert_req[1] <= 1'b1;
    repeat (6) @(posedge aclk);
    chk_bit("frozen sleep", 1'b0, cpu_sleeping);
    clk_en <= 1'b1;
    repeat (6) @(posedge aclk);
    chk_bit("sleep after enable", 1'b1, cpu_sleeping);
    assert_req[1] <= 1'b0;
    $display("test clock enable finished");
    end_of_test();
  end
endmodule : test_cpu_sideband_power_signals
